// ### common/rpsc_pkg.sv
// Package with the constants and types of the RF port switch control block.
// Contract
// - Single-port receive: RX switch on, shared amp off.
// - Single-port transmit: RX switch off, shared amp on.
// - Single-port bias: high on transmit, low receive.
// - Dual-port: shared amp off, RX switch for receive.
// - Dual-port: dedicated amp on only for transmit.
// - Dual-port: receive pins are never driven.
// - Dual-port bias follows transmit or receive state.
// - Bit 12 selects single port, reset dual.
// - Bit 14 enables bias output, else tri-stated.
// - Bit 13 inverts bias sense, reset zero.
// - Invert acts only in enabled dual-port mode.
package rpsc_pkg;

    // AXI4-Lite geometry.
    localparam int AXI_AW = 8;
    localparam int AXI_DW = 32;
    localparam int ADDR_LSB = 2;
    localparam int WORD_W = AXI_AW - ADDR_LSB;
    localparam int STRB_W = AXI_DW / 8;

    // Register indices; the byte address is four times the index.
    localparam logic [WORD_W-1:0] CFG_IDX = 6'h07;
    localparam logic [WORD_W-1:0] STAT_IDX = 6'h08;

    // Front-end configuration register.
    localparam int CFG_W = 16;
    localparam logic [CFG_W-1:0] CFG_RST = 16'h0000;
    localparam int BIT_SEL = 12;
    localparam int BIT_INV = 13;
    localparam int BIT_EN = 14;

    // Status register fields.
    localparam int ST_W = 10;
    localparam int ST_MODE = 0;
    localparam int ST_RXSW = 3;
    localparam int ST_AMPS = 4;
    localparam int ST_AMPD = 5;
    localparam int ST_BLVL = 6;
    localparam int ST_BOE = 7;
    localparam int ST_DRV = 8;
    localparam int ST_GRD = 9;

    // Response codes.
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Radio state as presented by the modem sequencer.
    typedef enum logic [2:0] {
        RPSC_IDLE,
        RPSC_RX,
        RPSC_TX,
        RPSC_DOZE,
        RPSC_HIB,
        RPSC_OFF
    } rpsc_radio_t;

endpackage

// ### common/rpsc_path_if.sv
// Interface that carries configuration and decoded path controls.
`timescale 1ns/1ps
interface rpsc_path_if;
    import rpsc_pkg::*;
    rpsc_radio_t state;
    logic single_port;
    logic bias_en;
    logic bias_inv;
    logic rx_sw;
    logic amp_shared;
    logic amp_ded;
    logic pins_drive;
    logic bias_lvl;
    logic bias_drive;

    modport ctrl (
        output state, single_port, bias_en, bias_inv,
        input rx_sw, amp_shared, amp_ded, pins_drive, bias_lvl, bias_drive
    );
    modport dec (
        input state, single_port, bias_en, bias_inv,
        output rx_sw, amp_shared, amp_ded, pins_drive, bias_lvl, bias_drive
    );
endinterface

// ### src/rpsc_path_decode.sv
// Decoder from radio state and configuration to front-end controls.
`timescale 1ns/1ps
module rpsc_path_decode
    import rpsc_pkg::*;
(
    rpsc_path_if.dec p
);

    wire is_rx = (p.state == RPSC_RX);
    wire is_tx = (p.state == RPSC_TX);
    wire is_low = (p.state == RPSC_IDLE) || (p.state == RPSC_DOZE) ||
        (p.state == RPSC_HIB);
    wire is_off = ~(is_rx | is_tx | is_low);

    // Receive uses the LNA path in both modes.
    assign p.rx_sw = is_rx;
    assign p.amp_shared = is_tx & p.single_port;
    assign p.amp_ded = is_tx & ~p.single_port;
    // Only the shared amplifier ever drives the shared pin pair.
    assign p.pins_drive = is_tx & p.single_port;

    // The invert bit is forced out of effect in single-port mode.
    wire bias_pol = p.single_port ? 1'b0 : p.bias_inv;
    assign p.bias_lvl = (is_tx | is_rx) & (is_tx ^ bias_pol);
    // Low-power states still drive low; power-off releases the pin.
    assign p.bias_drive = p.bias_en & ~is_off;

endmodule

// ### src/rpsc_top.sv
// Top of the RF port switch control block with its AXI4-Lite slave.
`timescale 1ns/1ps
module rpsc_top
    import rpsc_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address
    input wire logic [AXI_AW-1:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic awvalid,
    output logic awready,
    // AXI4-Lite write data
    input wire logic [AXI_DW-1:0] wdata,
    input wire logic [STRB_W-1:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // AXI4-Lite write response
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // AXI4-Lite read address
    input wire logic [AXI_AW-1:0] araddr,
    input wire logic [2:0] arprot,
    input wire logic arvalid,
    output logic arready,
    // AXI4-Lite read data
    output logic [AXI_DW-1:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Radio state from the modem sequencer
    input wire logic [2:0] radio_state,
    // Front-end controls
    output logic rx_switch_en,
    output logic shared_path_amp_en,
    output logic dedicated_path_amp_en,
    output logic rf_pins_drive_en,
    output logic switched_bias_out_o,
    output logic switched_bias_out_oe
);

    rpsc_path_if p ();

    rpsc_path_decode u_dec (
        .p(p)
    );

    // Register file state.
    logic [CFG_W-1:0] cfg_r;
    logic sel_q_r;
    rpsc_radio_t mode_r;
    logic guard_r;

    // Write channel state.
    logic awready_r;
    logic wready_r;
    logic aw_held_r;
    logic w_held_r;
    logic [WORD_W-1:0] aw_word_r;
    logic [AXI_DW-1:0] wdata_r;
    logic [STRB_W-1:0] wstrb_r;
    logic bvalid_r;
    logic [1:0] bresp_r;

    // Read channel state.
    logic arready_r;
    logic rvalid_r;
    logic [1:0] rresp_r;
    logic [AXI_DW-1:0] rdata_r;

    // Front-end output flops.
    logic rx_sw_r;
    logic amp_s_r;
    logic amp_d_r;
    logic drv_r;
    logic bias_r;
    logic bias_oe_r;

    // Write decode.
    wire aw_take = awvalid & awready_r;
    wire w_take = wvalid & wready_r;
    wire wr_fire = aw_held_r & w_held_r & ~bvalid_r;
    wire wr_cfg_hit = (aw_word_r == CFG_IDX);
    wire wr_stat_hit = (aw_word_r == STAT_IDX);
    wire wr_cfg = wr_fire & wr_cfg_hit;
    wire [1:0] wr_resp = (wr_cfg_hit | wr_stat_hit) ? RESP_OKAY : RESP_SLVERR;
    wire b_done = bvalid_r & bready;

    // Read decode.
    wire ar_take = arvalid & arready_r;
    wire r_done = rvalid_r & rready;
    wire [WORD_W-1:0] ar_word = araddr[AXI_AW-1:ADDR_LSB];
    wire rd_cfg_hit = (ar_word == CFG_IDX);
    wire rd_stat_hit = (ar_word == STAT_IDX);
    wire [ST_W-1:0] status_w;
    wire [AXI_DW-1:0] rd_val;
    wire [1:0] rd_resp = (rd_cfg_hit | rd_stat_hit) ? RESP_OKAY : RESP_SLVERR;

    assign status_w[ST_MODE+:3] = mode_r;
    assign status_w[ST_RXSW] = rx_sw_r;
    assign status_w[ST_AMPS] = amp_s_r;
    assign status_w[ST_AMPD] = amp_d_r;
    assign status_w[ST_BLVL] = bias_r;
    assign status_w[ST_BOE] = bias_oe_r;
    assign status_w[ST_DRV] = drv_r;
    assign status_w[ST_GRD] = guard_r;

    assign rd_val = rd_cfg_hit ? {{(AXI_DW-CFG_W){1'b0}}, cfg_r} :
        rd_stat_hit ? {{(AXI_DW-ST_W){1'b0}}, status_w} :
        {AXI_DW{1'b0}};

    // Address and data are caught separately, so either may come first.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_r <= 1'b1;
            aw_held_r <= 1'b0;
            aw_word_r <= '0;
        end else if (aw_take) begin
            awready_r <= 1'b0;
            aw_held_r <= 1'b1;
            aw_word_r <= awaddr[AXI_AW-1:ADDR_LSB];
        end else if (b_done) begin
            awready_r <= 1'b1;
            aw_held_r <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wready_r <= 1'b1;
            w_held_r <= 1'b0;
            wdata_r <= '0;
            wstrb_r <= '0;
        end else if (w_take) begin
            wready_r <= 1'b0;
            w_held_r <= 1'b1;
            wdata_r <= wdata;
            wstrb_r <= wstrb;
        end else if (b_done) begin
            wready_r <= 1'b1;
            w_held_r <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_r <= 1'b1;
            bresp_r <= wr_resp;
        end else if (b_done) begin
            bvalid_r <= 1'b0;
        end
    end

    // Byte lanes of the configuration word; the status word ignores writes.
    for (genvar b = 0; b < CFG_W / 8; b++) begin : g_lane
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                cfg_r[b*8+:8] <= CFG_RST[b*8+:8];
            end else if (wr_cfg && wstrb_r[b]) begin
                cfg_r[b*8+:8] <= wdata_r[b*8+:8];
            end
        end
    end

    // Read answers one edge after the address is taken.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_r <= 1'b1;
            rvalid_r <= 1'b0;
            rresp_r <= RESP_OKAY;
            rdata_r <= '0;
        end else if (ar_take) begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b1;
            rresp_r <= rd_resp;
            rdata_r <= rd_val;
        end else if (r_done) begin
            arready_r <= 1'b1;
            rvalid_r <= 1'b0;
        end
    end

    // Radio state comes from logic on this clock, so it is not synchronised.
    wire mode_chg = (rpsc_radio_t'(radio_state) != mode_r);
    wire sel_chg = (cfg_r[BIT_SEL] != sel_q_r);

    // A change of state or port mode gives one cycle with every path off,
    // so the switch and an amplifier are never on together in transit.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_r <= RPSC_IDLE;
            sel_q_r <= CFG_RST[BIT_SEL];
            guard_r <= 1'b0;
        end else begin
            mode_r <= rpsc_radio_t'(radio_state);
            sel_q_r <= cfg_r[BIT_SEL];
            guard_r <= mode_chg | sel_chg;
        end
    end

    assign p.state = mode_r;
    assign p.single_port = sel_q_r;
    assign p.bias_en = cfg_r[BIT_EN];
    assign p.bias_inv = cfg_r[BIT_INV];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_sw_r <= 1'b0;
            amp_s_r <= 1'b0;
            amp_d_r <= 1'b0;
            drv_r <= 1'b0;
        end else begin
            rx_sw_r <= p.rx_sw & ~guard_r;
            amp_s_r <= p.amp_shared & ~guard_r;
            amp_d_r <= p.amp_ded & ~guard_r;
            drv_r <= p.pins_drive & ~guard_r;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bias_r <= 1'b0;
            bias_oe_r <= 1'b0;
        end else begin
            bias_r <= p.bias_lvl & p.bias_drive;
            bias_oe_r <= p.bias_drive;
        end
    end

    assign awready = awready_r;
    assign wready = wready_r;
    assign bvalid = bvalid_r;
    assign bresp = bresp_r;
    assign arready = arready_r;
    assign rvalid = rvalid_r;
    assign rresp = rresp_r;
    assign rdata = rdata_r;
    assign rx_switch_en = rx_sw_r;
    assign shared_path_amp_en = amp_s_r;
    assign dedicated_path_amp_en = amp_d_r;
    assign rf_pins_drive_en = drv_r;
    assign switched_bias_out_o = bias_r;
    assign switched_bias_out_oe = bias_oe_r;

endmodule

// ### testbench/rpsc_assertions.sv
// Concurrent checks on the ports of the RF port switch control top.
`timescale 1ns/1ps
module rpsc_checker
    import rpsc_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Register bus response
    input wire logic bvalid,
    // Radio state
    input wire logic [2:0] radio_state,
    // Front-end controls
    input wire logic rx_switch_en,
    input wire logic shared_path_amp_en,
    input wire logic dedicated_path_amp_en,
    input wire logic rf_pins_drive_en,
    input wire logic switched_bias_out_o,
    input wire logic switched_bias_out_oe
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_amps_exclusive: assert property (
        !(shared_path_amp_en && dedicated_path_amp_en))
        else $error("both amplifiers enabled");
    a_rx_blocks_amps: assert property (
        rx_switch_en |-> !shared_path_amp_en && !dedicated_path_amp_en)
        else $error("amplifier on while receive switch on");
    a_pins_need_shared: assert property (
        rf_pins_drive_en |-> shared_path_amp_en)
        else $error("receive pins driven outside shared transmit");
    // A config write that changes the port select also darkens the path, so quiet bus cycles are required.
    a_rx_switch_on: assert property (
        (radio_state == RPSC_RX && !bvalid) [*4] |-> rx_switch_en)
        else $error("receive switch off in steady receive");
    a_amp_after_tx: assert property (
        shared_path_amp_en || dedicated_path_amp_en
        |-> $past(radio_state, 2) == RPSC_TX)
        else $error("amplifier on without transmit");
    a_bias_hiz_low: assert property (
        !switched_bias_out_oe |-> !switched_bias_out_o)
        else $error("bias level while released");
    a_bias_single_tx: assert property (
        shared_path_amp_en && switched_bias_out_oe |-> switched_bias_out_o)
        else $error("bias low in single-port transmit");
    a_bias_idle_low: assert property (
        (radio_state == RPSC_IDLE && !bvalid) [*4] |-> !switched_bias_out_o)
        else $error("bias high while idle");

    cover property (shared_path_amp_en && switched_bias_out_oe);
    cover property (dedicated_path_amp_en && switched_bias_out_o);
    cover property (rx_switch_en && switched_bias_out_o);
endmodule

bind rpsc_top rpsc_checker rpsc_checker_inst (.aclk, .aresetn, .bvalid,
    .radio_state, .rx_switch_en, .shared_path_amp_en,
    .dedicated_path_amp_en, .rf_pins_drive_en, .switched_bias_out_o,
    .switched_bias_out_oe);

// ### testbench/rpsc_ant_switch.sv
// Behavioural antenna switch steered by the switched bias pin.
`timescale 1ns/1ps
module rpsc_ant_switch (
    // Bias pin as split by the block
    input wire logic bias_o,
    input wire logic bias_oe,
    // Switch position, high selects the transmit path
    output logic tx_sel
);
    // A pull-down parks the switch on receive while the pin is released.
    assign tx_sel = bias_oe ? bias_o : 1'b0;
endmodule

// ### testbench/tb.sv
// Self-checking bench for the RF port switch control block.
`timescale 1ns/1ps
module tb;
    import rpsc_pkg::*;
    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, ant_tx;
    logic rx_switch_en, shared_path_amp_en, dedicated_path_amp_en;
    logic rf_pins_drive_en, switched_bias_out_o, switched_bias_out_oe;
    logic [AXI_AW-1:0] awaddr, araddr;
    logic [AXI_DW-1:0] wdata, rdata, d, got;
    logic [1:0] bresp, rresp, resp;
    logic [2:0] radio_state;
    logic [6:0] fe, m;
    int miscompares, n_checks, v;

    assign fe = {rx_switch_en, shared_path_amp_en, dedicated_path_amp_en,
        rf_pins_drive_en, switched_bias_out_oe, switched_bias_out_o, ant_tx};

    rpsc_top rpsc_top_inst (.aclk, .aresetn, .awaddr, .awprot(3'h0),
        .awvalid, .awready, .wdata, .wstrb(4'hf), .wvalid, .wready, .bresp,
        .bvalid, .bready, .araddr, .arprot(3'h0), .arvalid, .arready, .rdata,
        .rresp, .rvalid, .rready, .radio_state, .rx_switch_en,
        .shared_path_amp_en, .dedicated_path_amp_en, .rf_pins_drive_en,
        .switched_bias_out_o, .switched_bias_out_oe);
    rpsc_ant_switch rpsc_ant_switch_inst (.bias_o(switched_bias_out_o),
        .bias_oe(switched_bias_out_oe), .tx_sel(ant_tx));

    initial begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string s, input logic [31:0] e,
                       input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", s, e, g);
        end
    endtask

    task automatic limit(ref int n);
        n++;
        if (n > 100) begin
            miscompares++;
            print_verdict();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] dv);
        int n;
        n = 0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= dv;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            limit(n);
        end while (bvalid !== 1'b1);
        resp = bresp;
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a);
        int n;
        n = 0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            limit(n);
        end while (rvalid !== 1'b1);
        got = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask

    // Bits: 0 single port, 1 invert, 2 bias enable, 5:3 radio state.
    function automatic logic [6:0] model(input int c);
        logic sp, tx, rx, oe, o;
        sp = c[0];
        tx = (c[5:3] == 2);
        rx = (c[5:3] == 1);
        oe = c[2] && c[5:3] < 5;
        o = oe && (rx || tx) && (sp ? tx : tx ^ c[1]);
        return {rx, sp && tx, !sp && tx, sp && tx, oe, o, o};
    endfunction

    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata, radio_state} = '0;
        miscompares = 0;
        n_checks = 0;
        void'($urandom(80));
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        chk("reset outputs", 32'h0, {25'h0, fe});
        // A status write is answered but must leave the configuration alone.
        wr(8'h20, 32'hffff_ffff);
        chk("status write", {30'h0, RESP_OKAY}, {30'h0, resp});
        rd(8'h1c);
        chk("cfg reset", 32'h0, got);
        rd(8'h04);
        chk("unmapped read", {30'h0, RESP_SLVERR}, {30'h0, resp});
        wr(8'h3c, 32'hffff_ffff);
        chk("unmapped write", {30'h0, RESP_SLVERR}, {30'h0, resp});
        // Every mode, enable, invert and state first, then random mixes.
        for (int i = 0; i < 104; i++) begin
            v = (i < 64) ? i : $urandom_range(63, 0);
            d = $urandom;
            d[14:12] = v[2:0];
            wr(8'h1c, d);
            chk("cfg write", {30'h0, RESP_OKAY}, {30'h0, resp});
            radio_state <= v[5:3];
            repeat (4) @(posedge aclk);
            chk("front end", {25'h0, model(v)}, {25'h0, fe});
            rd(8'h1c);
            chk("cfg readback", {16'h0, d[15:0]}, got);
            m = model(v);
            rd(8'h20);
            chk("status resp", {30'h0, RESP_OKAY}, {30'h0, resp});
            chk("status", {22'h0, 1'b0, m[3], m[2], m[1], m[4], m[5], m[6],
                v[5:3]}, got);
        end
        // A reset in mid-run must bring back dual port with the pin released.
        radio_state <= 3'h0;
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        chk("mid-run reset outputs", 32'h0, {25'h0, fe});
        rd(8'h1c);
        chk("cfg after reset", 32'h0, got);
        print_verdict();
    end
endmodule
